// ### hw/uscfg_pkg.sv
// Functional notes
// - Load stored configuration after every reset.
// - Optionally pull FIFO lines low in suspend.
// - Wake request resumes host after about 20 ms.
// - Flag charging port detected while suspended.
// - Charger output polarity selectable, active high by default.
// - Shorted data lines force the suspended state.
// - Enumerated by host keeps charger output inactive.
// - Stay-awake input blocks suspend when unplugged.
// - Bus power sense input detects powered host.
// - No bus power keeps suspend unless stay-awake is held, pull-up off.
// - Default descriptor version is 0200, full speed.
// - Default descriptor is bus powered, 90 mA.
package uscfg_pkg;
   // Avalon-MM byte offsets.
   localparam logic [4:0] OFF_STATUS   = 5'h00;
   localparam logic [4:0] OFF_IRQ_STAT = 5'h04;
   localparam logic [4:0] OFF_IRQ_MASK = 5'h08;
   localparam logic [4:0] OFF_OPTIONS  = 5'h0c;
   localparam logic [4:0] OFF_DESC     = 5'h10;

   // Interrupt bit positions; status matches in bits 0-1, has charger at bit 2, wake busy at bit 3.
   localparam int IRQ_LOAD_DONE = 0;
   localparam int IRQ_SUSPEND   = 1;
   localparam int IRQ_WAKE_DONE = 2;
   localparam int IRQ_CHARGER   = 3;
   localparam int IRQ_BITS      = 4;

   // Stored word indices and option field positions.
   localparam logic [1:0] WORD_OPTIONS = 2'h0;
   localparam logic [1:0] WORD_VERSION = 2'h1;
   localparam logic [1:0] WORD_POWER   = 2'h2;
   localparam logic [1:0] CFG_WORDS    = 2'h3;
   localparam int OPT_PULLDOWN  = 0;
   localparam int OPT_WAKE      = 1;
   localparam int OPT_CHG_LOW   = 2;
   localparam int OPT_SELF_PWR  = 3;
   localparam int OPT_PIN5_CHG  = 4;
   localparam int OPT_PIN6_CHG  = 5;
   localparam int OPT_BITS      = 6;

   // Factory defaults.
   localparam logic [OPT_BITS-1:0] OPTIONS_RESET = 6'h00;
   localparam logic [15:0] USB_VERSION_RESET = 16'h0200;
   localparam int MAX_POWER_MA = 90;
   localparam logic [7:0] MAX_POWER_RESET = 8'(MAX_POWER_MA / 2);

   // Pin synchroniser order and reset levels.
   localparam int PIN_WAKE_N  = 0;
   localparam int PIN_VBUS    = 1;
   localparam int PIN_AWAKE_N = 2;
   localparam int PIN_SHORTED = 3;
   localparam int PIN_COUNT   = 4;
   localparam logic [PIN_COUNT-1:0] PIN_RESET = 4'h5;

   // Timing.
   localparam int CLK_MHZ = 125;
   localparam int WAKE_TIME_MS = 20;
   localparam int WAKE_CYCLES = WAKE_TIME_MS * CLK_MHZ * 1000;

   typedef enum logic [1:0] {
      LD_START,
      LD_REQ,
      LD_WAIT,
      LD_IDLE
   } uscfg_load_e;
endpackage

// ### hw/uscfg_top.sv
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module uscfg_top #(
   parameter int WAKE_CYCLES = uscfg_pkg::WAKE_CYCLES
) (
   input  wire logic        sys_clk,          // 125 MHz clock
   input  wire logic        rst,              // Synchronous reset, active high
   input  wire logic [4:0]  avs_address,      // Byte address
   input  wire logic        avs_read,         // Read request
   input  wire logic        avs_write,        // Write request
   input  wire logic [31:0] avs_writedata,    // Write data
   input  wire logic [3:0]  avs_byteenable,   // Byte enables
   output logic      [31:0] avs_readdata,     // Read data
   output logic             avs_waitrequest,  // Stall until answer
   output logic             irq,              // Level interrupt
   output logic      [1:0]  storeAddr,        // Config store word index
   output logic             storeRead,        // Config store read strobe
   input  wire logic [15:0] storeData,        // Config store word
   input  wire logic        storeValid,       // Config store word valid
   input  wire logic        usbBusReset,      // USB bus reset pulse from core
   input  wire logic        usbIdle,          // Host idle, suspend request from core
   input  wire logic        enumerated,       // Device enumerated by host
   input  wire logic        wakeRequestN,     // Remote wake pin, active low
   input  wire logic        busPowerSense,    // Bus power sense pin
   input  wire logic        stayAwakeN,       // Stay-awake pin, active low
   input  wire logic        dataLinesShorted, // Data lines shorted detector
   output logic             configReady,      // Configuration loaded
   output logic             powerEnableN,     // High while suspended
   output logic             fifoPullDown,     // Pull FIFO lines low
   output logic             pullupEnable,     // Full-speed pull-up connect
   output logic             resumeDrive,      // Resume signalling to host
   output logic             chargerDetectOut, // Charger detect, set polarity
   output logic      [15:0] descVersion,      // Descriptor USB version
   output logic      [7:0]  descMaxPower,     // Descriptor max power, 2 mA units
   output logic             descSelfPowered   // Descriptor power source
);
   localparam int WCW = $clog2(WAKE_CYCLES + 1);

   if (WAKE_CYCLES < 1) begin : g_bad_wake
      $error("WAKE_CYCLES must be at least one");
   end

   // Pin synchronisers.
   logic [uscfg_pkg::PIN_COUNT-1:0] pinRaw;
   logic [uscfg_pkg::PIN_COUNT-1:0] meta_reg;
   logic [uscfg_pkg::PIN_COUNT-1:0] sync_reg;
   assign pinRaw[uscfg_pkg::PIN_WAKE_N]  = wakeRequestN;
   assign pinRaw[uscfg_pkg::PIN_VBUS]    = busPowerSense;
   assign pinRaw[uscfg_pkg::PIN_AWAKE_N] = stayAwakeN;
   assign pinRaw[uscfg_pkg::PIN_SHORTED] = dataLinesShorted;

   genvar gi;
   generate
      for (gi = 0; gi < uscfg_pkg::PIN_COUNT; gi++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               meta_reg[gi] <= uscfg_pkg::PIN_RESET[gi];
               sync_reg[gi] <= uscfg_pkg::PIN_RESET[gi];
            end else begin
               meta_reg[gi] <= pinRaw[gi];
               sync_reg[gi] <= meta_reg[gi];
            end
         end
      end
   endgenerate

   // Configuration loader.
   uscfg_pkg::uscfg_load_e loadState_reg;
   uscfg_pkg::uscfg_load_e loadState_next;
   logic [1:0]                    wordIdx_reg;
   logic [uscfg_pkg::OPT_BITS-1:0] options_reg;
   logic [15:0]                   version_reg;
   logic [7:0]                    maxPower_reg;
   logic                          ready_reg;
   logic                          lastWord;
   logic                          loadDone;

   assign lastWord = (wordIdx_reg == uscfg_pkg::CFG_WORDS - 2'h1);
   assign loadDone = (loadState_reg == uscfg_pkg::LD_WAIT) && storeValid && lastWord;

   always_comb begin
      loadState_next = loadState_reg;
      case (loadState_reg)
         uscfg_pkg::LD_START: loadState_next = uscfg_pkg::LD_REQ;
         uscfg_pkg::LD_REQ:   loadState_next = uscfg_pkg::LD_WAIT;
         uscfg_pkg::LD_WAIT: begin
            if (storeValid) begin
               loadState_next = lastWord ? uscfg_pkg::LD_IDLE : uscfg_pkg::LD_REQ;
            end
         end
         uscfg_pkg::LD_IDLE:  loadState_next = uscfg_pkg::LD_IDLE;
         default:             loadState_next = uscfg_pkg::LD_START;
      endcase
      if (usbBusReset) begin
         loadState_next = uscfg_pkg::LD_START;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         loadState_reg <= uscfg_pkg::LD_START;
         wordIdx_reg   <= 2'h0;
         ready_reg     <= 1'b0;
         storeRead     <= 1'b0;
         storeAddr     <= 2'h0;
      end else begin
         loadState_reg <= loadState_next;
         storeRead     <= (loadState_next == uscfg_pkg::LD_REQ);
         // The word index goes out together with the strobe that asks for it.
         if (loadState_next == uscfg_pkg::LD_START) begin
            wordIdx_reg <= 2'h0;
            storeAddr   <= 2'h0;
            ready_reg   <= 1'b0;
         end else if (loadState_reg == uscfg_pkg::LD_WAIT && storeValid) begin
            wordIdx_reg <= wordIdx_reg + 2'h1;
            storeAddr   <= wordIdx_reg + 2'h1;
            ready_reg   <= lastWord;
         end
      end
   end

   // Shadow copies change only when a load reads the store.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         options_reg  <= uscfg_pkg::OPTIONS_RESET;
         version_reg  <= uscfg_pkg::USB_VERSION_RESET;
         maxPower_reg <= uscfg_pkg::MAX_POWER_RESET;
      end else if (loadState_reg == uscfg_pkg::LD_WAIT && storeValid && !usbBusReset) begin
         case (wordIdx_reg)
            uscfg_pkg::WORD_OPTIONS: options_reg  <= storeData[uscfg_pkg::OPT_BITS-1:0];
            uscfg_pkg::WORD_VERSION: version_reg  <= storeData;
            uscfg_pkg::WORD_POWER:   maxPower_reg <= storeData[7:0];
            default:                 options_reg  <= options_reg;
         endcase
      end
   end

   // Suspend and power management.
   logic optPullDown;
   logic optWake;
   logic optChgLow;
   logic vbusPresent;
   logic stayAwake;
   logic chargerPort;
   logic suspendWanted;
   logic suspended_reg;
   logic suspendEnter;

   assign optPullDown = options_reg[uscfg_pkg::OPT_PULLDOWN];
   assign optWake     = options_reg[uscfg_pkg::OPT_WAKE];
   assign optChgLow   = options_reg[uscfg_pkg::OPT_CHG_LOW];
   // A pin given over to the charger output no longer acts as its input.
   assign vbusPresent = options_reg[uscfg_pkg::OPT_PIN5_CHG] | sync_reg[uscfg_pkg::PIN_VBUS];
   assign stayAwake   = !options_reg[uscfg_pkg::OPT_PIN6_CHG] & !sync_reg[uscfg_pkg::PIN_AWAKE_N];
   assign chargerPort = sync_reg[uscfg_pkg::PIN_SHORTED];
   assign suspendWanted = chargerPort
                        | (!vbusPresent & !stayAwake)
                        | (usbIdle & !stayAwake);
   assign suspendEnter = suspendWanted && !suspended_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         suspended_reg <= 1'b1;
         powerEnableN  <= 1'b1;
         fifoPullDown  <= 1'b0;
         pullupEnable  <= 1'b0;
      end else begin
         suspended_reg <= suspendWanted;
         powerEnableN  <= suspendWanted;
         fifoPullDown  <= suspendWanted & optPullDown;
         pullupEnable  <= vbusPresent & ready_reg & !chargerPort;
      end
   end

   // Remote wake: a falling wake request in suspend starts resume timing.
   logic          wakePrev_reg;
   logic          wakeFall;
   logic [WCW-1:0] wakeCount_reg;
   logic          wakeBusy;
   logic          wakeDone;

   assign wakeFall = wakePrev_reg && !sync_reg[uscfg_pkg::PIN_WAKE_N];
   assign wakeBusy = (wakeCount_reg != '0);
   assign wakeDone = (wakeCount_reg == WCW'(1));

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wakePrev_reg  <= 1'b1;
         wakeCount_reg <= '0;
         resumeDrive   <= 1'b0;
      end else begin
         wakePrev_reg <= sync_reg[uscfg_pkg::PIN_WAKE_N];
         if (wakeFall && optWake && suspended_reg && !wakeBusy) begin
            wakeCount_reg <= WCW'(WAKE_CYCLES);
         end else if (wakeBusy) begin
            wakeCount_reg <= wakeCount_reg - WCW'(1);
         end
         resumeDrive <= wakeDone;
      end
   end

   // Charging-port detection output.
   logic chargerActive;
   logic chargerPrev_reg;

   assign chargerActive = chargerPort & suspended_reg & !enumerated;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         chargerPrev_reg  <= 1'b0;
         chargerDetectOut <= 1'b0;
      end else begin
         chargerPrev_reg  <= chargerActive;
         chargerDetectOut <= chargerActive ^ optChgLow;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         configReady     <= 1'b0;
         descVersion     <= uscfg_pkg::USB_VERSION_RESET;
         descMaxPower    <= uscfg_pkg::MAX_POWER_RESET;
         descSelfPowered <= 1'b0;
      end else begin
         configReady     <= ready_reg;
         descVersion     <= version_reg;
         descMaxPower    <= maxPower_reg;
         descSelfPowered <= options_reg[uscfg_pkg::OPT_SELF_PWR];
      end
   end

   // Register bus: answer one edge after the request is seen.
   logic                          busReq;
   logic                          busTake;
   logic                          wrLow;
   logic                          selStatus;
   logic                          selIrqStat;
   logic                          selIrqMask;
   logic                          selOptions;
   logic                          selDesc;
   logic [31:0]                   readMux;
   logic [uscfg_pkg::IRQ_BITS-1:0] irqStat_reg;
   logic [uscfg_pkg::IRQ_BITS-1:0] irqMask_reg;
   logic [uscfg_pkg::IRQ_BITS-1:0] irqEvents;
   logic [uscfg_pkg::IRQ_BITS-1:0] irqClear;
   logic [uscfg_pkg::IRQ_BITS-1:0] irqStat_next;

   assign busReq     = avs_read | avs_write;
   assign busTake    = busReq && !avs_waitrequest;
   assign wrLow      = busTake && avs_write && avs_byteenable[0];
   assign selStatus  = (avs_address == uscfg_pkg::OFF_STATUS);
   assign selIrqStat = (avs_address == uscfg_pkg::OFF_IRQ_STAT);
   assign selIrqMask = (avs_address == uscfg_pkg::OFF_IRQ_MASK);
   assign selOptions = (avs_address == uscfg_pkg::OFF_OPTIONS);
   assign selDesc    = (avs_address == uscfg_pkg::OFF_DESC);

   assign readMux = selStatus  ? {28'h0000000, wakeBusy, chargerActive, suspended_reg, ready_reg} :
                    selIrqStat ? {28'h0000000, irqStat_reg} :
                    selIrqMask ? {28'h0000000, irqMask_reg} :
                    selOptions ? {26'h0, options_reg} :
                    selDesc    ? {version_reg, 8'h00, maxPower_reg} :
                                 32'h00000000;

   assign irqEvents[uscfg_pkg::IRQ_LOAD_DONE] = loadDone;
   assign irqEvents[uscfg_pkg::IRQ_SUSPEND]   = suspendEnter;
   assign irqEvents[uscfg_pkg::IRQ_WAKE_DONE] = wakeDone;
   assign irqEvents[uscfg_pkg::IRQ_CHARGER]   = chargerActive && !chargerPrev_reg;
   assign irqClear     = (wrLow && selIrqStat) ? avs_writedata[uscfg_pkg::IRQ_BITS-1:0] : '0;
   // A new event wins over a clear in the same cycle.
   assign irqStat_next = (irqStat_reg & ~irqClear) | irqEvents;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else begin
         avs_waitrequest <= !(busReq && avs_waitrequest);
         if (busReq && avs_waitrequest) begin
            avs_readdata <= avs_read ? readMux : 32'h00000000;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irqStat_reg <= '0;
         irqMask_reg <= '0;
         irq         <= 1'b0;
      end else begin
         irqStat_reg <= irqStat_next;
         if (wrLow && selIrqMask) begin
            irqMask_reg <= avs_writedata[uscfg_pkg::IRQ_BITS-1:0];
         end
         irq <= |(irqStat_next & irqMask_reg);
      end
   end
endmodule
`default_nettype wire

// ### tb/uscfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module uscfg_props (
   input wire logic        sys_clk,          // Clock
   input wire logic        rst,              // Reset
   input wire logic [4:0]  avs_address,      // Address
   input wire logic        avs_read,         // Read
   input wire logic        avs_write,        // Write
   input wire logic [31:0] avs_readdata,     // Read data
   input wire logic        avs_waitrequest,  // Stall
   input wire logic [1:0]  storeAddr,        // Word index
   input wire logic        storeRead,        // Word strobe
   input wire logic        storeValid,       // Word valid
   input wire logic        usbBusReset,      // Bus reset
   input wire logic        configReady,      // Loaded
   input wire logic        powerEnableN,     // Suspended
   input wire logic        fifoPullDown,     // Pull-down
   input wire logic        pullupEnable,     // Pull-up
   input wire logic        busPowerSense,    // Bus power
   input wire logic        stayAwakeN,       // Stay awake
   input wire logic        dataLinesShorted, // Charging port
   input wire logic        resumeDrive,      // Resume
   input wire logic [15:0] descVersion,      // Version
   input wire logic [7:0]  descMaxPower,     // Max power
   input wire logic        descSelfPowered   // Power source
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest did not drop");
   a_wait_short_low: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_unmapped_reads_zero: assert property (avs_read && avs_waitrequest &&
      !(avs_address inside {5'h00, 5'h04, 5'h08, 5'h0c, 5'h10}) |=> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_load_restart: assert property (usbBusReset |-> ##[1:4] (storeRead && storeAddr == 2'h0))
      else $error("bus reset did not restart load");
   a_ready_after_load: assert property (storeValid && storeAddr == 2'h2 |-> ##[1:3] configReady)
      else $error("load did not complete");
   a_pulldown_in_suspend: assert property (fifoPullDown |-> powerEnableN)
      else $error("pull-down outside suspend");
   a_no_power_pullup: assert property (!busPowerSense [*5] |-> !pullupEnable)
      else $error("pull-up without bus power");
   a_no_power_suspend: assert property ((!busPowerSense && stayAwakeN) [*5] |-> powerEnableN)
      else $error("awake without bus power");
   a_shorted_suspends: assert property (dataLinesShorted [*5] |-> powerEnableN)
      else $error("shorted lines not suspended");
   a_stay_awake_holds: assert property ((!stayAwakeN && !dataLinesShorted) [*5] |-> !powerEnableN)
      else $error("suspended while stay-awake held");
   a_desc_defaults: assert property ($past(rst) |-> descVersion == 16'h0200 && descMaxPower == 8'h2d
      && !descSelfPowered)
      else $error("descriptor reset values wrong");
   c_resume: cover property (resumeDrive);
   c_bus_reset: cover property (usbBusReset ##[1:4] storeRead);
   c_read_done: cover property (avs_read && !avs_waitrequest);
endmodule
bind uscfg_top uscfg_props u_uscfg_props (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .storeAddr, .storeRead, .storeValid, .usbBusReset, .configReady, .powerEnableN,
   .fifoPullDown, .pullupEnable, .busPowerSense, .stayAwakeN, .dataLinesShorted, .resumeDrive, .descVersion,
   .descMaxPower, .descSelfPowered);
`default_nettype wire

// ### tb/uscfg_store_model.sv
`timescale 1ns/1ps
`default_nettype none
module uscfg_store_model (
   input  wire logic        sys_clk,    // Clock
   input  wire logic        rst,        // Reset
   input  wire logic [1:0]  storeAddr,  // Word index
   input  wire logic        storeRead,  // Word strobe
   output logic      [15:0] storeData,  // Word
   output logic             storeValid, // Word valid
   input  wire logic [15:0] optWord,    // Options word
   input  wire logic [15:0] verWord,    // Version word
   input  wire logic [15:0] pwrWord,    // Power word
   input  wire logic [3:0]  latency     // Answer delay
);
   logic [3:0] cnt;
   logic [1:0] addr;
   // Outside an answer the data lines toggle so no stale word can be mistaken for a fresh one.
   always_ff @(posedge sys_clk) begin
      storeValid <= 1'b0;
      storeData <= ~storeData;
      if (rst) begin
         cnt <= 4'h0;
         storeData <= 16'h0;
      end else if (storeRead) begin
         cnt <= latency;
         addr <= storeAddr;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
         if (cnt == 4'h1) begin
            storeValid <= 1'b1;
            storeData <= (addr == 2'h0) ? optWord : (addr == 2'h1) ? verWord : pwrWord;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/uscfg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uscfg_top_tb;
   localparam int WK = 20;
   logic        sys_clk, rst, avs_read, avs_write, avs_waitrequest, irq, storeRead, storeValid;
   logic        usbBusReset, usbIdle, enumerated, wakeRequestN, busPowerSense, stayAwakeN, dataLinesShorted;
   logic        configReady, powerEnableN, fifoPullDown, pullupEnable, resumeDrive, chargerDetectOut;
   logic        descSelfPowered;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [1:0]  storeAddr;
   logic [15:0] storeData, descVersion, optWord, verWord, pwrWord;
   logic [7:0]  descMaxPower;
   logic [3:0]  lat;
   int          mismatches, n_tests, cyc;
   uscfg_top #(.WAKE_CYCLES(WK)) u_uscfg_top (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .irq, .storeAddr, .storeRead,
      .storeData, .storeValid, .usbBusReset, .usbIdle, .enumerated, .wakeRequestN, .busPowerSense, .stayAwakeN,
      .dataLinesShorted, .configReady, .powerEnableN, .fifoPullDown, .pullupEnable, .resumeDrive,
      .chargerDetectOut, .descVersion, .descMaxPower, .descSelfPowered);
   uscfg_store_model u_uscfg_store_model (.sys_clk, .rst, .storeAddr, .storeRead, .storeData, .storeValid,
      .optWord, .verWord, .pwrWord, .latency(lat));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic end_of_test();
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 5000) begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (configReady !== 1'b1 && n < 100);
   endtask
   task automatic pins(input logic v, input logic s, input logic d, input logic e);
      busPowerSense <= v;
      stayAwakeN <= s;
      dataLinesShorted <= d;
      enumerated <= e;
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic t_regs();
      rd(5'h10, 32'h0200_002d);
      chk(descSelfPowered, 1'b0);
      rd(5'h00, 32'h1);
      wr(5'h0c, 32'h3f);
      rd(5'h0c, 32'h0);
      wr(5'h14, 32'hff);
      rd(5'h14, 32'h0);
      wr(5'h08, 32'h1);
      rd(5'h08, 32'h1);
      chk(irq, 1'b1);
      wr(5'h04, 32'h1);
      chk(irq, 1'b0);
      rd(5'h04, 32'h0);
      wr(5'h08, 32'h0);
   endtask
   task automatic t_charger(input logic pol);
      pins(1'b1, 1'b1, 1'b1, 1'b0);
      chk(powerEnableN, 1'b1);
      chk(chargerDetectOut, pol);
      pins(1'b1, 1'b1, 1'b1, 1'b1);
      chk(chargerDetectOut, !pol);
      pins(1'b1, 1'b1, 1'b0, 1'b0);
      chk(powerEnableN, 1'b0);
   endtask
   task automatic t_reload();
      optWord <= 16'h000f;
      verWord <= 16'h0110;
      pwrWord <= 16'h0032;
      lat <= 4'h6;
      repeat (4) @(posedge sys_clk);
      rd(5'h0c, 32'h0);
      usbBusReset <= 1'b1;
      @(posedge sys_clk);
      usbBusReset <= 1'b0;
      repeat (3) @(posedge sys_clk);
      wait_ready();
      rd(5'h0c, 32'hf);
      rd(5'h10, 32'h0110_0032);
      chk({descVersion, descMaxPower, 7'h0, descSelfPowered}, 32'h0110_3201);
   endtask
   task automatic t_suspend();
      pins(1'b0, 1'b1, 1'b0, 1'b0);
      chk(powerEnableN, 1'b1);
      chk(fifoPullDown, 1'b1);
      chk(pullupEnable, 1'b0);
      pins(1'b1, 1'b1, 1'b0, 1'b0);
      chk(pullupEnable, 1'b1);
      chk(fifoPullDown, 1'b0);
      usbIdle <= 1'b1;
      pins(1'b0, 1'b0, 1'b0, 1'b0);
      chk(powerEnableN, 1'b0);
      pins(1'b1, 1'b1, 1'b0, 1'b0);
      chk(powerEnableN, 1'b1);
      usbIdle <= 1'b0;
      pins(1'b1, 1'b1, 1'b0, 1'b0);
   endtask
   task automatic t_wake();
      int n;
      pins(1'b0, 1'b1, 1'b0, 1'b0);
      wr(5'h04, 32'hf);
      wakeRequestN <= 1'b0;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (resumeDrive !== 1'b1 && n < 100);
      chk(32'(n >= WK && n <= WK + 8), 32'h1);
      rd(5'h04, 32'h4);
      wakeRequestN <= 1'b1;
      pins(1'b1, 1'b1, 1'b0, 1'b0);
   endtask
   initial begin
      rst = 1'b1;
      avs_address = 5'h0;
      avs_writedata = 32'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      usbBusReset = 1'b0;
      usbIdle = 1'b0;
      enumerated = 1'b0;
      wakeRequestN = 1'b1;
      busPowerSense = 1'b1;
      stayAwakeN = 1'b1;
      dataLinesShorted = 1'b0;
      optWord = 16'h0;
      verWord = 16'h0200;
      pwrWord = 16'h002d;
      lat = 4'h2;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      wait_ready();
      t_regs();
      t_charger(1'b1);
      t_reload();
      t_suspend();
      t_wake();
      t_charger(1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire
